/* File: core/rot_map.svh */
`ifndef ROT_MAP_SVH
`define ROT_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_INSTR     8'h04
`define OFS_ACC       8'h08
`define OFS_FLAGS     8'h0C
`define OFS_BANK      8'h10
`define OFS_INDEX     8'h14
`define OFS_MADDR     8'h18
`define OFS_MDATA     8'h1C
`define OFS_STATE     8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_EXT_BIT  0
`define FLG_C_BIT     0
`define FLG_Z_BIT     2
`define FLG_N_BIT     4
`define ST_BUSY_BIT   0
`define ST_ILL_BIT    1
`define ST_PHASE_LSB  4

// ----------------------------------------------------------------------
// Opcodes, address split and reset values
// ----------------------------------------------------------------------
`define OPC_RLNC      6'h11
`define OPC_RRC       6'h0C
`define ACCESS_SPLIT  8'h60
`define LITERAL_MAX   8'h5F
`define ACC_RST       8'h00
`define INSTR_RST     16'h0000

`endif

/* File: core/rot_pkg.sv */
package rot_pkg;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_RLNC = 2'b01,
    OP_RRC  = 2'b10
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DECODE = 3'b001,
    ST_READ   = 3'b010,
    ST_PROC   = 3'b011,
    ST_WRITE  = 3'b100
  } state_t;

  typedef struct packed {
    logic [5:0] opc;
    logic       dest;
    logic       banked;
    logic [7:0] faddr;
  } instr_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
  } flags_t;

endpackage : rot_pkg

/* File: core/rotate_core.sv */
`timescale 1ns/10ps
`default_nettype none

module rotate_core
  import rot_pkg::*;
(
  input  wire op_t        op,       // Rotate kind
  input  wire logic [7:0] operand,  // Byte read from the file
  input  wire flags_t     flg_in,   // Flags before the instruction
  output var  logic [7:0] result,   // Rotated byte
  output var  flags_t     flg_out   // Flags after the instruction
);

  always_comb begin
    result  = operand;
    flg_out = flg_in;
    unique case (op)
      OP_RLNC: begin
        result = {operand[6:0], operand[7]};
      end
      OP_RRC: begin
        result    = {flg_in.c, operand[7:1]};
        flg_out.c = operand[0];
      end
      OP_NONE: begin
        result = operand;
      end
    endcase
    // Carry is left alone for the left rotate
    if (op != OP_NONE) begin
      flg_out.n = result[7];
      flg_out.z = (result == 8'h00);
    end
  end

endmodule : rotate_core

`default_nettype wire

/* File: core/rotate_instruction_unit.sv */
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "rot_map.svh"

module rotate_instruction_unit
  import rot_pkg::*;
#(
  parameter int ADDR_W = 12           // File address width, bank plus byte
)(
  input  wire logic        clock,     // Core clock
  input  wire logic        arst_n,    // Asynchronous reset, active low
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB access phase
  input  wire logic        pwrite,    // APB write
  input  wire logic [7:0]  paddr,     // APB byte address
  input  wire logic [31:0] pwdata,    // APB write data
  output var  logic        pready,    // APB ready
  output var  logic [31:0] prdata,    // APB read data
  output var  logic        pslverr    // APB error
);

  localparam int BANK_W = ADDR_W - 8;
  localparam int DEPTH  = 1 << ADDR_W;

  generate
    if (ADDR_W < 9 || ADDR_W > 16) begin : g_bad_width
      $error("ADDR_W must lie between 9 and 16");
    end
  endgenerate

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  state_t              state_ff;
  instr_t              instr_ff;
  op_t                 op_ff;
  logic [ADDR_W-1:0]   addr_ff;
  logic [7:0]          opnd_ff;
  logic [7:0]          res_ff;
  flags_t              res_flg_ff;
  logic [7:0]          acc_ff;
  flags_t              flg_ff;
  logic [BANK_W-1:0]   bank_ff;
  logic [ADDR_W-1:0]   index_ff;
  logic [ADDR_W-1:0]   maddr_ff;
  logic                ext_ff;
  logic                ill_ff;
  logic                pready_ff;
  logic [31:0]         prdata_ff;
  logic                pslverr_ff;
  logic [7:0]          file_mem [DEPTH];

  logic                acc_phase;
  logic                wr_ok;
  logic                rd_map;
  logic                busy;
  logic [7:0]          alu_res;
  flags_t              alu_flg;
  op_t                 nxt_op;
  logic [ADDR_W-1:0]   nxt_addr;
  logic [31:0]         nxt_rdata;

  assign busy      = (state_ff != ST_IDLE);
  assign acc_phase = psel && penable && pready_ff;
  // Register writes during an instruction are refused so the datapath
  // never sees a half-updated operand or accumulator.
  // The refusal is taken from the setup cycle's error decision, so the
  // error flag and the update agree even when busy drops mid-transfer.
  assign wr_ok     = acc_phase && pwrite && !pslverr_ff;

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  always_comb begin
    unique case (instr_ff.opc)
      `OPC_RLNC: nxt_op = OP_RLNC;
      `OPC_RRC:  nxt_op = OP_RRC;
      default:   nxt_op = OP_NONE;
    endcase
  end

  always_comb begin
    if (instr_ff.banked) begin
      nxt_addr = {bank_ff, instr_ff.faddr};
    end else if (ext_ff && instr_ff.faddr <= `LITERAL_MAX) begin
      nxt_addr = index_ff + {{BANK_W{1'b0}}, instr_ff.faddr};
    end else if (instr_ff.faddr < `ACCESS_SPLIT) begin
      nxt_addr = {{BANK_W{1'b0}}, instr_ff.faddr};
    end else begin
      // Upper access half maps onto the top bank
      nxt_addr = {{BANK_W{1'b1}}, instr_ff.faddr};
    end
  end

  rotate_core u_core (
    .op      (op_ff),
    .operand (opnd_ff),
    .flg_in  (flg_ff),
    .result  (alu_res),
    .flg_out (alu_flg)
  );

  // --------------------------------------------------------------------
  // Phase sequencer
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (wr_ok && paddr == `OFS_INSTR) begin
            state_ff <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          state_ff <= (nxt_op == OP_NONE) ? ST_IDLE : ST_READ;
        end
        ST_READ:  state_ff <= ST_PROC;
        ST_PROC:  state_ff <= ST_WRITE;
        ST_WRITE: state_ff <= ST_IDLE;
        default:  state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      op_ff   <= OP_NONE;
      addr_ff <= '0;
      ill_ff  <= 1'b0;
    end else if (state_ff == ST_DECODE) begin
      op_ff   <= nxt_op;
      addr_ff <= nxt_addr;
      ill_ff  <= (nxt_op == OP_NONE);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      opnd_ff    <= 8'h00;
      res_ff     <= 8'h00;
      res_flg_ff <= '0;
    end else if (state_ff == ST_READ) begin
      opnd_ff <= file_mem[addr_ff];
    end else if (state_ff == ST_PROC) begin
      res_ff     <= alu_res;
      res_flg_ff <= alu_flg;
    end
  end

  // --------------------------------------------------------------------
  // Destination write and software registers
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (state_ff == ST_WRITE && instr_ff.dest) begin
      file_mem[addr_ff] <= res_ff;
    end else if (wr_ok && paddr == `OFS_MDATA) begin
      file_mem[maddr_ff] <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      acc_ff <= `ACC_RST;
      flg_ff <= '0;
    end else if (state_ff == ST_WRITE) begin
      if (!instr_ff.dest) begin
        acc_ff <= res_ff;
      end
      flg_ff <= res_flg_ff;
    end else if (wr_ok && paddr == `OFS_ACC) begin
      acc_ff <= pwdata[7:0];
    end else if (wr_ok && paddr == `OFS_FLAGS) begin
      flg_ff.c <= pwdata[`FLG_C_BIT];
      flg_ff.z <= pwdata[`FLG_Z_BIT];
      flg_ff.n <= pwdata[`FLG_N_BIT];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      instr_ff <= `INSTR_RST;
      bank_ff  <= '0;
      index_ff <= '0;
      maddr_ff <= '0;
      ext_ff   <= 1'b0;
    end else if (wr_ok) begin
      unique case (paddr)
        `OFS_INSTR: instr_ff <= pwdata[15:0];
        `OFS_BANK:  bank_ff  <= pwdata[BANK_W-1:0];
        `OFS_INDEX: index_ff <= pwdata[ADDR_W-1:0];
        `OFS_MADDR: maddr_ff <= pwdata[ADDR_W-1:0];
        `OFS_CTRL:  ext_ff   <= pwdata[`CTRL_EXT_BIT];
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  always_comb begin
    rd_map    = 1'b1;
    nxt_rdata = 32'h0000_0000;
    unique case (paddr)
      `OFS_CTRL:  nxt_rdata[`CTRL_EXT_BIT] = ext_ff;
      `OFS_INSTR: nxt_rdata[15:0] = instr_ff;
      `OFS_ACC:   nxt_rdata[7:0]  = acc_ff;
      `OFS_FLAGS: begin
        nxt_rdata[`FLG_C_BIT] = flg_ff.c;
        nxt_rdata[`FLG_Z_BIT] = flg_ff.z;
        nxt_rdata[`FLG_N_BIT] = flg_ff.n;
      end
      `OFS_BANK:  nxt_rdata[BANK_W-1:0] = bank_ff;
      `OFS_INDEX: nxt_rdata[ADDR_W-1:0] = index_ff;
      `OFS_MADDR: nxt_rdata[ADDR_W-1:0] = maddr_ff;
      `OFS_MDATA: nxt_rdata[7:0]  = file_mem[maddr_ff];
      `OFS_STATE: begin
        nxt_rdata[`ST_BUSY_BIT] = busy;
        nxt_rdata[`ST_ILL_BIT]  = ill_ff;
        nxt_rdata[`ST_PHASE_LSB +: 3] = state_ff;
      end
      default: rd_map = 1'b0;
    endcase
  end

  // Ready rises in the first access cycle: every transfer has no wait
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel && !penable;
      prdata_ff  <= (psel && !penable) ? nxt_rdata : 32'h0000_0000;
      pslverr_ff <= psel && !penable && (!rd_map || (pwrite && busy)
                    || (pwrite && paddr == `OFS_STATE));
    end
  end

  assign pready  = pready_ff;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  rlnc_result_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (state_ff == ST_PROC && op_ff == OP_RLNC) |=>
      res_ff == {opnd_ff[6:0], opnd_ff[7]} && res_flg_ff.c == flg_ff.c)
    else $error("left rotate result or carry wrong");

  rrc_carry_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (state_ff == ST_WRITE && op_ff == OP_RRC) |=>
      flg_ff.c == $past(opnd_ff[0], 2) && acc_ff[7] == $past(flg_ff.c, 3)
      || $past(instr_ff.dest))
    else $error("right rotate carry path wrong");

  acc_dest_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (state_ff == ST_WRITE && !instr_ff.dest) |=> acc_ff == $past(res_ff))
    else $error("accumulator not loaded");

  file_dest_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (state_ff == ST_WRITE && instr_ff.dest) |=> acc_ff == $past(acc_ff))
    else $error("accumulator changed on file target");

  bank_select_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (state_ff == ST_DECODE && instr_ff.banked && nxt_op != OP_NONE) |=>
      addr_ff == {$past(bank_ff), $past(instr_ff.faddr)})
    else $error("banked address wrong");

  literal_ofs_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (state_ff == ST_DECODE && ext_ff && !instr_ff.banked
      && instr_ff.faddr <= 8'h5F && nxt_op != OP_NONE) |=>
      addr_ff == ADDR_W'($past(index_ff) + $past(instr_ff.faddr)))
    else $error("indexed literal address wrong");

  illegal_op_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (state_ff == ST_DECODE && instr_ff.opc != 6'h11 && instr_ff.opc != 6'h0C)
      |=> state_ff == ST_IDLE && ill_ff)
    else $error("foreign opcode executed");

  four_phase_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (state_ff == ST_DECODE && nxt_op != OP_NONE) |=>
      state_ff == ST_READ ##1 state_ff == ST_PROC ##1 state_ff == ST_WRITE
      ##1 state_ff == ST_IDLE)
    else $error("phase sequence broken");

endmodule : rotate_instruction_unit

`default_nettype wire

/* File: test/test_rotate_instruction_unit.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rot_map.svh"

module test_rotate_instruction_unit
  import rot_pkg::*;
;
  logic        clock;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [31:0] rd;
  logic        err;
  int          failures;
  int          total_checks;
  int          cycles;

  rotate_instruction_unit i_rotate_instruction_unit (
    .clock   (clock),
    .arst_n  (arst_n),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr)
  );

  // ----------------------------------------------------------------------
  // Clock, hang guard and verdict
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  task automatic complete_run();
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // Whole sequence needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------------
  // Bus access and comparison
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One idle cycle after each transfer keeps psel from being driven twice
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1) begin
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
    chk("write_err", 32'h0, {31'h0, err});
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk

  task automatic mset(input logic [31:0] a, input logic [31:0] d);
    wr(`OFS_MADDR, a);
    wr(`OFS_MDATA, d);
  endtask : mset

  task automatic mchk(input logic [31:0] a, input logic [31:0] e);
    wr(`OFS_MADDR, a);
    rdchk("file_byte", `OFS_MDATA, e);
  endtask : mchk

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'h0, `OFS_STATE, 32'h0);
      n++;
    end while (rd[`ST_BUSY_BIT] !== 1'h0 && n < 10);
    chk("idle_busy", 32'h0, {31'h0, rd[`ST_BUSY_BIT]});
  endtask : wait_idle

  task automatic run(input logic [5:0] op, input logic d, input logic a,
                     input logic [7:0] f);
    wr(`OFS_INSTR, {16'h0, op, d, a, f});
    wait_idle();
  endtask : run

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    arst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge clock);
    arst_n <= 1'h1;
    @(posedge clock);
    rdchk("acc", `OFS_ACC, 32'h0);
    rdchk("flags", `OFS_FLAGS, 32'h0);
    rdchk("state", `OFS_STATE, 32'h0);
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    apb(1'h1, `OFS_STATE, 32'h0000_00FF);
    chk("state_write_err", 32'h1, {31'h0, err});
    // Banked left rotate at the top byte of bank 3, carry must survive
    wr(`OFS_BANK, 32'h3);
    mset(32'h3FF, 32'hAB);
    wr(`OFS_FLAGS, 32'h1);
    run(`OPC_RLNC, 1'h1, 1'h1, 8'hFF);
    mchk(32'h3FF, 32'h57);
    rdchk("flags", `OFS_FLAGS, 32'h1);
    rdchk("acc", `OFS_ACC, 32'h0);
    // Access bank, result to accumulator, negative flag
    mset(32'h020, 32'hC0);
    wr(`OFS_FLAGS, 32'h0);
    run(`OPC_RLNC, 1'h0, 1'h0, 8'h20);
    rdchk("acc", `OFS_ACC, 32'h81);
    rdchk("flags", `OFS_FLAGS, 32'h10);
    mchk(32'h020, 32'hC0);
    // Right rotate from the upper access half
    mset(32'hF80, 32'hE6);
    run(`OPC_RRC, 1'h0, 1'h0, 8'h80);
    rdchk("acc", `OFS_ACC, 32'h73);
    rdchk("flags", `OFS_FLAGS, 32'h0);
    mchk(32'hF80, 32'hE6);
    // Old carry enters bit 7, bit 0 leaves into carry
    wr(`OFS_FLAGS, 32'h1);
    run(`OPC_RRC, 1'h1, 1'h1, 8'hFF);
    mchk(32'h3FF, 32'hAB);
    rdchk("flags", `OFS_FLAGS, 32'h11);
    mset(32'h020, 32'h01);
    wr(`OFS_FLAGS, 32'h0);
    run(`OPC_RRC, 1'h1, 1'h0, 8'h20);
    mchk(32'h020, 32'h0);
    rdchk("flags", `OFS_FLAGS, 32'h05);
    // Indexed literal offset up to the boundary address only
    wr(`OFS_CTRL, 32'h1);
    wr(`OFS_INDEX, 32'h200);
    mset(32'h25F, 32'h12);
    mset(32'h05F, 32'h99);
    run(`OPC_RLNC, 1'h1, 1'h0, 8'h5F);
    mchk(32'h25F, 32'h24);
    mchk(32'h05F, 32'h99);
    mset(32'hF60, 32'h80);
    apb(1'h1, `OFS_INSTR, {16'h0, `OPC_RLNC, 1'h0, 1'h0, 8'h60});
    // A write landing mid-instruction must be refused
    apb(1'h1, `OFS_ACC, 32'h0000_00FF);
    chk("busy_err", 32'h1, {31'h0, err});
    wait_idle();
    rdchk("acc", `OFS_ACC, 32'h01);
    run(6'h3F, 1'h0, 1'h0, 8'h00);
    rdchk("state", `OFS_STATE, 32'h2);
    complete_run();
  end
endmodule : test_rotate_instruction_unit
`default_nettype wire
